// [hw/eivl_core.sv]
// Module: encoder index handling, position compare and vector load limit
//
// Contract
// - Index qualifies only when A and B match configured levels or skip is set.
// - Index input active level follows the index polarity setting.
// - Skip channel qualify setting ignores A and B levels.
// - Continuous clearing performs the index action on every index.
// - One-shot clearing acts only on the next qualified index.
// - Rising trigger detects entry into active level, disables level mode.
// - Falling trigger detects exit from active level, disables level mode.
// - Index copies position to latch; optionally clears position.
// - Compare source selects ramp position or encoder position.
// - Encoder constant fraction divides by 65536 or 10000.
// - Vector constant is signed 6.6; zero turns vector control off.
// - Electrical angle is readable, writable, in 1/256 periods.
// - Codes 00 and 01 take table bits 12:5 and 11:4.
// - Codes 10 and 11 take table bits 9:2 and 7:0.
// - Load limit is 64, 72, 80 or 88 of 256 per code.
// - Index status flag sets on event, clears on read.
// - Read-only latch holds position from the latest index.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module eivl_core
	import eivl_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// Encoder pins
	input  wire logic        enc_a_i,
	input  wire logic        enc_b_i,
	input  wire logic        enc_n_i,
	// Motion inputs from same clock domain
	input  wire logic [31:0] ramp_pos_i,
	input  wire logic [31:0] enc_pos_i,
	input  wire logic [12:0] table_pos_i,
	input  wire logic        enc_tick_i,
	input  wire logic        enc_dir_i,
	// Register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// Outputs
	output logic      [31:0] enc_pos_o,
	output logic             enc_pos_clr_o,
	output logic      [31:0] enc_divisor_o,
	output logic             position_pulse_output_o,
	output logic      [12:0] table_pos_o,
	output logic             table_pos_ld_o,
	output logic             irq_o
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  a_sync;
		logic [2:0]  b_sync;
		logic [2:0]  n_sync;
		logic        a_st;
		logic        b_st;
		logic        n_st;
		logic        act_prev;
		eivl_arm_e   arm;
		logic [13:0] cfg;
		logic [31:0] div;
		logic [11:0] vconst;
		logic [9:0]  vsel;
		logic [7:0]  vangle;
		logic [11:0] vfrac;
		logic [31:0] cmp;
		logic [31:0] latch;
		logic [31:0] pos;
		logic        pos_clr;
		logic        index_flag;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic [31:0] rdata;
		logic        pulse;
		logic [12:0] tab;
		logic        tab_ld;
		logic        irq;
	} eivl_state_s;

	eivl_state_s s_q;
	eivl_state_s s_d;

	// Picks the electrical angle field for a resolution code
	function automatic logic [7:0] eivl_angle(input logic [12:0] p,
	                                          input logic [1:0] code);
		case (code)
			2'h0:    eivl_angle = p[12:5];
			2'h1:    eivl_angle = p[11:4];
			2'h2:    eivl_angle = p[9:2];
			default: eivl_angle = p[7:0];
		endcase
	endfunction : eivl_angle

	// Signed angle difference wrapped into one electrical period
	function automatic logic signed [7:0] eivl_diff(input logic [7:0] a,
	                                                input logic [7:0] b);
		eivl_diff = $signed(a - b);
	endfunction : eivl_diff

	logic        active;
	logic        qual;
	logic        edge_mode;
	logic        detect;
	logic        event_hit;
	logic        wr_hit;
	logic        rd_hit;
	logic [7:0]  limit;
	logic [7:0]  tab_ang;
	logic signed [7:0] lead;
	logic [7:0]  ang_new;
	logic [12:0] frac_sum;
	logic [7:0]  fix_ang;

	always_comb begin
		s_d = s_q;
		wr_hit = reg_wr_i;
		rd_hit = reg_rd_i;

		// ---------------------------------------------------------------
		// Pin synchronisers; change counts once stages two and three agree
		// ---------------------------------------------------------------
		s_d.a_sync = {s_q.a_sync[1:0], enc_a_i};
		s_d.b_sync = {s_q.b_sync[1:0], enc_b_i};
		s_d.n_sync = {s_q.n_sync[1:0], enc_n_i};
		if (s_q.a_sync[1] == s_q.a_sync[2]) begin
			s_d.a_st = s_q.a_sync[2];
		end
		if (s_q.b_sync[1] == s_q.b_sync[2]) begin
			s_d.b_st = s_q.b_sync[2];
		end
		if (s_q.n_sync[1] == s_q.n_sync[2]) begin
			s_d.n_st = s_q.n_sync[2];
		end

		// ---------------------------------------------------------------
		// Index qualification and detection
		// ---------------------------------------------------------------
		active = (s_q.n_st == s_q.cfg[EIVL_B_INDEX_POL]);
		qual = active &&
		       (s_q.cfg[EIVL_B_SKIP_QUAL] ||
		        ((s_q.a_st == s_q.cfg[EIVL_B_LEVEL_A]) &&
		         (s_q.b_st == s_q.cfg[EIVL_B_LEVEL_B])));
		s_d.act_prev = qual;
		edge_mode = s_q.cfg[EIVL_B_RISE] || s_q.cfg[EIVL_B_FALL];
		if (edge_mode) begin
			detect = (s_q.cfg[EIVL_B_RISE] && qual && !s_q.act_prev) ||
			         (s_q.cfg[EIVL_B_FALL] && !qual && s_q.act_prev);
		end else begin
			detect = qual;
		end

		// Level mode in one-shot fires once; continuous fires every cycle
		event_hit = 1'b0;
		case (s_q.arm)
			EIVL_ARM_IDLE: begin
				if (s_q.cfg[EIVL_B_CLR_CONT]) begin
					s_d.arm = EIVL_ARM_CONT;
				end else if (s_q.cfg[EIVL_B_CLR_ONCE]) begin
					s_d.arm = EIVL_ARM_WAIT;
				end
			end
			EIVL_ARM_WAIT: begin
				if (detect) begin
					event_hit = 1'b1;
					s_d.arm = EIVL_ARM_IDLE;
					s_d.cfg[EIVL_B_CLR_ONCE] = 1'b0;
				end
			end
			EIVL_ARM_CONT: begin
				event_hit = detect;
				if (!s_q.cfg[EIVL_B_CLR_CONT]) begin
					s_d.arm = EIVL_ARM_IDLE;
				end
			end
			default: s_d.arm = EIVL_ARM_IDLE;
		endcase

		// ---------------------------------------------------------------
		// Encoder count, latch and clear
		// ---------------------------------------------------------------
		s_d.pos = enc_pos_i;
		s_d.pos_clr = 1'b0;
		if (event_hit) begin
			s_d.latch = enc_pos_i;
			if (s_q.cfg[EIVL_B_CLR_POS]) begin
				s_d.pos = 32'h0000_0000;
				s_d.pos_clr = 1'b1;
			end
		end

		// ---------------------------------------------------------------
		// Comparator
		// ---------------------------------------------------------------
		s_d.pulse = s_q.cfg[EIVL_B_CMP_ENC] ? (enc_pos_i == s_q.cmp)
		                                    : (ramp_pos_i == s_q.cmp);

		// ---------------------------------------------------------------
		// Vector angle: accumulate signed 6.6 constant per encoder tick
		// ---------------------------------------------------------------
		frac_sum = 13'h0000;
		if (enc_tick_i && (s_q.vconst != EIVL_VCONST_RST)) begin
			frac_sum = {1'b0, s_q.vfrac} + {1'b0, s_q.vconst};
			if (enc_dir_i) begin
				frac_sum = {1'b0, s_q.vfrac} - {1'b0, s_q.vconst};
			end
			s_d.vfrac = {6'h00, frac_sum[5:0]};
			// Integer part is sign extended bits 11:6 of the sum, carry included
			s_d.vangle = s_q.vangle + {{2{frac_sum[11]}}, frac_sum[11:6]};
		end

		// Load limit clamp
		limit = EIVL_LOAD_BASE + (EIVL_LOAD_STEP *
		        {6'h00, s_q.vsel[EIVL_B_LOAD_LO+1:EIVL_B_LOAD_LO]});
		tab_ang = eivl_angle(table_pos_i, s_q.vsel[1:0]);
		lead = eivl_diff(tab_ang, s_q.vangle);
		fix_ang = tab_ang;
		s_d.tab_ld = 1'b0;
		if (s_q.vconst != EIVL_VCONST_RST) begin
			if (lead > $signed(limit)) begin
				fix_ang = s_q.vangle + limit;
				s_d.tab_ld = 1'b1;
			end else if (lead < -$signed(limit)) begin
				fix_ang = s_q.vangle - limit;
				s_d.tab_ld = 1'b1;
			end
		end
		ang_new = fix_ang;
		s_d.tab = table_pos_i;
		case (s_q.vsel[1:0])
			2'h0:    s_d.tab[12:5] = ang_new;
			2'h1:    s_d.tab[11:4] = ang_new;
			2'h2:    s_d.tab[9:2] = ang_new;
			default: s_d.tab[7:0] = ang_new;
		endcase

		// ---------------------------------------------------------------
		// Register writes
		// ---------------------------------------------------------------
		if (wr_hit) begin
			case (reg_addr_i)
				EIVL_IDX_CONFIG: s_d.cfg = reg_wdata_i[EIVL_CFG_W-1:0];
				EIVL_IDX_VCONST: s_d.vconst = reg_wdata_i[EIVL_VCONST_W-1:0];
				EIVL_IDX_VANGLE: s_d.vangle = reg_wdata_i[7:0];
				EIVL_IDX_VSEL:   s_d.vsel = reg_wdata_i[EIVL_VSEL_W-1:0];
				EIVL_IDX_COMPARE: s_d.cmp = reg_wdata_i;
				EIVL_IDX_IRQ_MASK: s_d.irq_mask = reg_wdata_i[1:0];
				EIVL_IDX_IRQ_STAT:
					s_d.irq_stat = s_q.irq_stat & ~reg_wdata_i[1:0];
				default: ;
			endcase
		end
		// Follows the new setting so the divisor never lags the config
		s_d.div = s_d.cfg[EIVL_B_DECIMAL] ? EIVL_DIV_DEC
		                                  : EIVL_DIV_BIN;

		// ---------------------------------------------------------------
		// Register reads, data one cycle later
		// ---------------------------------------------------------------
		s_d.rdata = 32'h0000_0000;
		if (rd_hit) begin
			case (reg_addr_i)
				EIVL_IDX_ENC_POS:  s_d.rdata = s_q.pos;
				EIVL_IDX_STATUS: begin
					s_d.rdata = {31'h0, s_q.index_flag};
					s_d.index_flag = 1'b0;
				end
				EIVL_IDX_LATCH:    s_d.rdata = s_q.latch;
				EIVL_IDX_VANGLE:   s_d.rdata = {24'h0, s_q.vangle};
				EIVL_IDX_COMPARE:  s_d.rdata = s_q.cmp;
				EIVL_IDX_IRQ_STAT: s_d.rdata = {30'h0, s_q.irq_stat};
				EIVL_IDX_IRQ_MASK: s_d.rdata = {30'h0, s_q.irq_mask};
				EIVL_IDX_TABLE_POS: s_d.rdata = {19'h0, s_q.tab};
				default:           s_d.rdata = 32'h0000_0000;
			endcase
		end

		// Hardware set wins over software clear
		if (event_hit) begin
			s_d.index_flag = 1'b1;
			s_d.irq_stat = s_d.irq_stat | EIVL_IRQ_INDEX;
		end
		if (s_d.pulse && !s_q.pulse) begin
			s_d.irq_stat = s_d.irq_stat | EIVL_IRQ_CMP;
		end
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_q <= '{arm: EIVL_ARM_IDLE, cfg: EIVL_CFG_RST, div: EIVL_DIV_BIN,
			         vconst: EIVL_VCONST_RST, vsel: EIVL_VSEL_RST,
			         default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rdata_o             = s_q.rdata;
	assign enc_pos_o               = s_q.pos;
	assign enc_pos_clr_o           = s_q.pos_clr;
	// Fractional divisor seen by the encoder accumulator
	assign enc_divisor_o           = s_q.div;
	assign position_pulse_output_o = s_q.pulse;
	assign table_pos_o             = s_q.tab;
	assign table_pos_ld_o          = s_q.tab_ld;
	assign irq_o                   = s_q.irq;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_latch;
		@(posedge clk_i) disable iff (!arst_n_i)
		event_hit |=> (s_q.latch == $past(enc_pos_i));
	endproperty
	a_latch: assert property (p_latch) else $error("latch miss");

	property p_clear;
		@(posedge clk_i) disable iff (!arst_n_i)
		(event_hit && s_q.cfg[EIVL_B_CLR_POS]) |=> enc_pos_clr_o;
	endproperty
	a_clear: assert property (p_clear) else $error("no clear");

	property p_flag;
		@(posedge clk_i) disable iff (!arst_n_i)
		event_hit |=> s_q.index_flag;
	endproperty
	a_flag: assert property (p_flag) else $error("flag lost");

	property p_qual;
		@(posedge clk_i) disable iff (!arst_n_i)
		(qual && !s_q.cfg[EIVL_B_SKIP_QUAL]) |->
		(s_q.a_st == s_q.cfg[EIVL_B_LEVEL_A]);
	endproperty
	a_qual: assert property (p_qual) else $error("bad qualify");

	property p_once;
		@(posedge clk_i) disable iff (!arst_n_i)
		(s_q.arm == EIVL_ARM_WAIT && event_hit) |=> (s_q.arm == EIVL_ARM_IDLE);
	endproperty
	a_once: assert property (p_once) else $error("one-shot repeat");

	property p_cmp;
		@(posedge clk_i) disable iff (!arst_n_i)
		(s_q.cfg[EIVL_B_CMP_ENC] && enc_pos_i == s_q.cmp) |=>
		position_pulse_output_o;
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare miss");

	property p_div;
		@(posedge clk_i) disable iff (!arst_n_i)
		s_q.cfg[EIVL_B_DECIMAL] |-> (enc_divisor_o == EIVL_DIV_DEC);
	endproperty
	a_div: assert property (p_div) else $error("divisor wrong");

	property p_off;
		@(posedge clk_i) disable iff (!arst_n_i)
		(s_q.vconst == EIVL_VCONST_RST) |=> !table_pos_ld_o;
	endproperty
	a_off: assert property (p_off) else $error("vector on at zero");

	property p_irq;
		@(posedge clk_i) disable iff (!arst_n_i)
		irq_o == |(s_q.irq_stat & s_q.irq_mask);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

endmodule : eivl_core

// [hw/eivl_pkg.sv]
// Package: register map, field positions and constants of the encoder index and vector limit block
package eivl_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is index times four)
	// ---------------------------------------------------------------
	localparam logic [7:0] EIVL_IDX_CONFIG    = 8'h12;
	localparam logic [7:0] EIVL_IDX_ENC_POS   = 8'h11;
	localparam logic [7:0] EIVL_IDX_STATUS    = 8'h13;
	localparam logic [7:0] EIVL_IDX_LATCH     = 8'h14;
	localparam logic [7:0] EIVL_IDX_VCONST    = 8'h17;
	localparam logic [7:0] EIVL_IDX_VANGLE    = 8'h18;
	localparam logic [7:0] EIVL_IDX_VSEL      = 8'h19;
	localparam logic [7:0] EIVL_IDX_COMPARE   = 8'h1a;
	localparam logic [7:0] EIVL_IDX_IRQ_STAT  = 8'h1b;
	localparam logic [7:0] EIVL_IDX_IRQ_MASK  = 8'h1c;
	localparam logic [7:0] EIVL_IDX_TABLE_POS = 8'h1d;

	// ---------------------------------------------------------------
	// Configuration and vector select field positions
	// ---------------------------------------------------------------
	localparam int EIVL_B_LEVEL_A     = 0;
	localparam int EIVL_B_LEVEL_B     = 1;
	localparam int EIVL_B_INDEX_POL   = 2;
	localparam int EIVL_B_SKIP_QUAL   = 3;
	localparam int EIVL_B_CLR_CONT    = 4;
	localparam int EIVL_B_CLR_ONCE    = 5;
	localparam int EIVL_B_RISE        = 6;
	localparam int EIVL_B_FALL        = 7;
	localparam int EIVL_B_CLR_POS     = 8;
	localparam int EIVL_B_CMP_ENC     = 12;
	localparam int EIVL_B_DECIMAL     = 13;
	localparam int EIVL_B_LOAD_LO     = 8;

	// ---------------------------------------------------------------
	// Widths, reset values and scaling
	// ---------------------------------------------------------------
	localparam int EIVL_CFG_W   = 14;
	localparam int EIVL_VCONST_W = 12;
	localparam int EIVL_VSEL_W  = 10;
	localparam int EIVL_TAB_W   = 13;
	localparam logic [13:0] EIVL_CFG_RST    = 14'h0000;
	localparam logic [11:0] EIVL_VCONST_RST = 12'h000;
	localparam logic [9:0]  EIVL_VSEL_RST   = 10'h000;
	localparam logic [31:0] EIVL_DIV_BIN    = 32'h0001_0000;
	localparam logic [31:0] EIVL_DIV_DEC    = 32'h0000_2710;
	localparam logic [7:0]  EIVL_LOAD_BASE  = 8'h40;
	localparam logic [7:0]  EIVL_LOAD_STEP  = 8'h08;
	localparam logic [1:0]  EIVL_IRQ_INDEX  = 2'h1;
	localparam logic [1:0]  EIVL_IRQ_CMP    = 2'h2;

	typedef enum logic [2:0] {
		EIVL_ARM_IDLE = 3'b001,
		EIVL_ARM_WAIT = 3'b010,
		EIVL_ARM_CONT = 3'b100
	} eivl_arm_e;

endpackage : eivl_pkg

// [test/eivl_enc_model.sv]
// Quadrature encoder model with index channel for the eivl bench
`timescale 1ns/100ps
module eivl_enc_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// Count clear request from the block
	input  wire logic        clr_i,
	// Encoder pins and count
	output logic             enc_a_o,
	output logic             enc_b_o,
	output logic             enc_n_o,
	output logic      [31:0] cnt_o
);
	logic       run = 1'b1;
	logic       act = 1'b0;
	logic       pol = 1'b1;
	logic [1:0] div;
	// ---------------------------------------------------------------
	// Pins: Gray code on A and B, index idles at the inactive level
	// ---------------------------------------------------------------
	assign enc_a_o = cnt_o[1];
	assign enc_b_o = cnt_o[1] ^ cnt_o[0];
	assign enc_n_o = act ? pol : ~pol;
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div   <= 2'h0;
			cnt_o <= 32'h0000_0100;
		end else begin
			div <= div + 2'h1;
			if (clr_i)
				cnt_o <= 32'h0;
			else if (run && div == 2'h3)
				cnt_o <= cnt_o + 32'h1;
		end
	end
	// Stops on the wanted A/B state so the latched count is known
	task automatic index(input logic a, input logic b,
		output logic [31:0] pos);
		run <= 1'b1;
		@(posedge clk_i);
		while (!(enc_a_o == a && enc_b_o == b && div == 2'h2))
			@(posedge clk_i);
		run <= 1'b0;
		@(posedge clk_i);
		pos = cnt_o;
		act <= 1'b1;
		repeat (8) @(posedge clk_i);
		act <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : index
endmodule : eivl_enc_model

// [test/testbench.sv]
// Self-checking bench for the encoder index and vector limit block
`timescale 1ns/100ps
module testbench;
	import eivl_pkg::*;
	logic        clk_i;
	logic        arst_n_i;
	logic [31:0] ramp_pos_i;
	logic [12:0] table_pos_i;
	logic [7:0]  reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [31:0] reg_rdata_o;
	logic [31:0] enc_divisor_o;
	logic        position_pulse_output_o;
	logic        enc_pos_clr_o;
	logic        table_pos_ld_o;
	logic        irq_o;
	logic        enc_tick;
	logic        enc_dir;
	logic [12:0] table_pos_o;
	logic [31:0] enc_pos_o;
	logic [31:0] s;
	logic [12:0] et;
	logic [7:0]  ang;
	logic [7:0]  va;
	logic [7:0]  nw;
	logic [7:0]  lim;
	int          sh;
	logic        enc_a;
	logic        enc_b;
	logic        enc_n;
	logic [31:0] enc_cnt;
	logic [32:0] exp_q[$];
	logic [32:0] q;
	logic        rd_dly;
	logic [31:0] p;
	int          fails;
	int          checked;
	int          seed;
	// ---------------------------------------------------------------
	// Design and encoder
	// ---------------------------------------------------------------
	eivl_core DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .enc_a_i(enc_a),
		.enc_b_i(enc_b), .enc_n_i(enc_n), .ramp_pos_i(ramp_pos_i),
		.enc_pos_i(enc_cnt), .table_pos_i(table_pos_i),
		.enc_tick_i(enc_tick), .enc_dir_i(enc_dir), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.enc_pos_o(enc_pos_o),
		.enc_pos_clr_o(enc_pos_clr_o), .enc_divisor_o(enc_divisor_o),
		.position_pulse_output_o(position_pulse_output_o),
		.table_pos_o(table_pos_o), .table_pos_ld_o(table_pos_ld_o),
		.irq_o(irq_o));
	eivl_enc_model enc (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.clr_i(enc_pos_clr_o), .enc_a_o(enc_a), .enc_b_o(enc_b),
		.enc_n_o(enc_n), .cnt_o(enc_cnt));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// ---------------------------------------------------------------
	// Bus tasks and comparisons
	// ---------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i    <= 1'b0;
	endtask : wr
	// A read with c low drains a flag whose state is not of interest
	task automatic rd(input logic [7:0] a, input logic c,
		input logic [31:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		exp_q.push_back({c, e});
		@(posedge clk_i);
		reg_rd_i   <= 1'b0;
	endtask : rd
	task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t rdata %h exp %h", $time, g, e);
		end
	endtask : cmp_rd
	task automatic cmp_out(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t output %h exp %h", $time, g, e);
		end
	endtask : cmp_out
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : settle
	task automatic end_of_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// Read data stand only in the cycle after the strobe
	always @(posedge clk_i) begin
		if (rd_dly && exp_q.size() > 0) begin
			q = exp_q.pop_front();
			if (q[32])
				cmp_rd(reg_rdata_o, q[31:0]);
		end
		rd_dly <= reg_rd_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		end_of_test();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		seed        = 32'hbd0d;
		ramp_pos_i  = $random(seed) | 32'h1;
		table_pos_i = 13'($random(seed));
		reg_addr_i  = 8'h00;
		reg_wdata_i = 32'h0;
		reg_wr_i    = 1'b0;
		reg_rd_i    = 1'b0;
		enc_tick    = 1'b0;
		enc_dir     = 1'b0;
		arst_n_i    = 1'b0;
		repeat (16) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(EIVL_IDX_STATUS, 1'b1, 32'h0);
		wr(8'h00, $random(seed));
		rd(8'h00, 1'b1, 32'h0);
		wr(EIVL_IDX_IRQ_STAT, 32'h3);
		// Level, continuous, A high and B low, index active high
		wr(EIVL_IDX_CONFIG, 32'h15);
		enc.index(1'b1, 1'b0, p);
		rd(EIVL_IDX_STATUS, 1'b1, 32'h1);
		rd(EIVL_IDX_STATUS, 1'b1, 32'h0);
		rd(EIVL_IDX_LATCH, 1'b1, p);
		settle(2);
		cmp_out(32'(irq_o), 32'h0);
		wr(EIVL_IDX_IRQ_MASK, 32'h1);
		settle(3);
		cmp_out(32'(irq_o), 32'h1);
		wr(EIVL_IDX_IRQ_STAT, 32'h1);
		settle(3);
		cmp_out(32'(irq_o), 32'h0);
		enc.index(1'b0, 1'b0, p);
		rd(EIVL_IDX_STATUS, 1'b1, 32'h0);
		wr(EIVL_IDX_CONFIG, 32'h1d);
		enc.index(1'b0, 1'b0, p);
		rd(EIVL_IDX_STATUS, 1'b1, 32'h1);
		rd(EIVL_IDX_LATCH, 1'b1, p);
		// One-shot, rising edge, clear the count
		wr(EIVL_IDX_CONFIG, 32'h16c);
		enc.index(1'b1, 1'b1, p);
		rd(EIVL_IDX_STATUS, 1'b1, 32'h1);
		rd(EIVL_IDX_LATCH, 1'b1, p);
		settle(1);
		cmp_out(enc_cnt, 32'h0);
		cmp_out(enc_pos_o, 32'h0);
		enc.index(1'b1, 1'b1, p);
		rd(EIVL_IDX_STATUS, 1'b1, 32'h0);
		// Index active low, falling edge, continuous
		enc.pol <= 1'b0;
		wr(EIVL_IDX_CONFIG, 32'h98);
		settle(8);
		rd(EIVL_IDX_STATUS, 1'b0, 32'h0);
		enc.index(1'b0, 1'b1, p);
		rd(EIVL_IDX_STATUS, 1'b1, 32'h1);
		rd(EIVL_IDX_LATCH, 1'b1, p);
		// Comparator source and divisor; the count stays frozen
		wr(EIVL_IDX_COMPARE, ramp_pos_i);
		wr(EIVL_IDX_CONFIG, 32'h0);
		settle(3);
		cmp_out(32'(position_pulse_output_o), 32'h1);
		cmp_out(enc_divisor_o, 32'd65536);
		wr(EIVL_IDX_CONFIG, 32'h3000);
		settle(3);
		cmp_out(32'(position_pulse_output_o), 32'h0);
		cmp_out(enc_divisor_o, 32'd10000);
		wr(EIVL_IDX_COMPARE, enc_cnt);
		settle(3);
		cmp_out(32'(position_pulse_output_o), 32'h1);
		cmp_out(32'(table_pos_ld_o), 32'h0);
		p = $random(seed) & 32'hff;
		wr(EIVL_IDX_VANGLE, p);
		rd(EIVL_IDX_VANGLE, 1'b1, p);
		// Vector clamp: lead above, below and inside the load limit
		for (int i = 0; i < 6; i++) begin
			s = $random(seed);
			sh = (s[16:15] == 2'h0) ? 5 : (s[16:15] == 2'h1) ? 4 :
			     (s[16:15] == 2'h2) ? 2 : 0;
			lim = EIVL_LOAD_BASE + EIVL_LOAD_STEP * {6'h00, s[14:13]};
			ang = 8'(s[12:0] >> sh);
			va = (i % 3 == 0) ? ang - lim - 8'h05 :
			     (i % 3 == 1) ? ang + lim + 8'h05 : ang - 8'h03;
			nw = (i % 3 == 0) ? ang - 8'h05 :
			     (i % 3 == 1) ? ang + 8'h05 : ang;
			et = (s[12:0] & ~(13'h0ff << sh)) | (13'(nw) << sh);
			table_pos_i <= s[12:0];
			wr(EIVL_IDX_VSEL, {22'h0, s[14:13], 6'h00, s[16:15]});
			wr(EIVL_IDX_VANGLE, {24'h0, va});
			wr(EIVL_IDX_VCONST, 32'h40);
			settle(2);
			cmp_out(32'(table_pos_ld_o), {31'h0, i % 3 != 2});
			cmp_out(32'(table_pos_o), 32'(et));
		end
		// One whole step per tick, up and then down
		enc_tick <= 1'b1;
		@(posedge clk_i);
		enc_tick <= 1'b0;
		rd(EIVL_IDX_VANGLE, 1'b1, {24'h0, va + 8'h01});
		enc_dir  <= 1'b1;
		enc_tick <= 1'b1;
		@(posedge clk_i);
		enc_tick <= 1'b0;
		enc_dir  <= 1'b0;
		rd(EIVL_IDX_VANGLE, 1'b1, {24'h0, va});
		settle(4);
		end_of_test();
	end
endmodule : testbench
